// file: hw/ssi_encoder_pkg.sv
// Shared constants and types of the serial absolute encoder port
package ssi_encoder_pkg;

	// System clock and recovery timing
	localparam int SYS_CLK_HZ = 20_000_000;
	localparam int SYS_CLK_MHZ = SYS_CLK_HZ / 1_000_000;
	localparam int RECOVERY_TIMEOUT_NS = 20000;
	// Least time, so round up to whole cycles
	localparam int RECOVERY_CYCLES_INT = (RECOVERY_TIMEOUT_NS * SYS_CLK_MHZ + 999) / 1000;
	localparam int TIMER_BITS = 9;
	localparam logic [8:0] RECOVERY_CYCLES = 9'(RECOVERY_CYCLES_INT);

	// Word layout
	localparam int ST_MAX_BITS = 14;
	localparam logic [3:0] ST_MIN_RES = 4'h9;
	localparam logic [3:0] ST_MAX_RES = 4'hE;
	localparam int MT_BITS = 12;
	localparam logic [5:0] MT_LEN = 6'h0C;
	localparam int BCD_BITS = 20;
	localparam logic [5:0] BCD_LEN = 6'h14;
	localparam int BCD_DIGITS = 5;
	localparam int WORD_BITS = 32;
	localparam logic [5:0] WORD_LEN = 6'h20;
	localparam int COUNT_BITS = 6;

	// Line levels
	localparam logic LINK_IDLE_LEVEL = 1'b1;
	localparam logic DATA_ACK_LEVEL = 1'b0;

	// Position code selection
	typedef enum logic [1:0] {CODE_BINARY, CODE_GRAY, CODE_BCD} code_e;

	// Readout sequencer phases
	typedef enum logic [1:0] {PH_IDLE, PH_SHIFT, PH_RECOVER} phase_e;

endpackage

// file: hw/position_coder.sv
// Position coder: zero offset, direction, code selection and word packing
`timescale 1ns/1ps
`default_nettype none
module position_coder
	import ssi_encoder_pkg::*;
(
	input wire logic [ST_MAX_BITS-1:0] angle_in,
	input wire logic [MT_BITS-1:0] turns_in,
	input wire logic [3:0] res_bits_in,
	input wire logic mt_enable_in,
	input wire code_e code_sel_in,
	input wire logic dir_invert_in,
	input wire logic [ST_MAX_BITS-1:0] zero_offset_in,
	output logic [WORD_BITS-1:0] word_out,
	output logic [COUNT_BITS-1:0] word_len_out
);

	// Binary to single-step code, used for both parts of the word
	function automatic logic [ST_MAX_BITS-1:0] to_gray(input logic [ST_MAX_BITS-1:0] v);
		to_gray = v ^ (v >> 1);
	endfunction

	// Shift-and-add-three, one decimal digit per nibble
	function automatic logic [BCD_BITS-1:0] to_bcd(input logic [ST_MAX_BITS-1:0] v);
		logic [BCD_BITS+ST_MAX_BITS-1:0] s;
		s = {{BCD_BITS{1'b0}}, v};
		for (int i = 0; i < ST_MAX_BITS; i++)
		begin
			for (int d = 0; d < BCD_DIGITS; d++)
			begin
				if (s[ST_MAX_BITS+4*d +: 4] >= 4'h5)
				begin
					s[ST_MAX_BITS+4*d +: 4] = s[ST_MAX_BITS+4*d +: 4] + 4'h3;
				end
			end
			s = s << 1;
		end
		to_bcd = s[BCD_BITS+ST_MAX_BITS-1:ST_MAX_BITS];
	endfunction

	logic [3:0] res;
	logic [ST_MAX_BITS-1:0] mask;
	logic [ST_MAX_BITS-1:0] st;
	logic [BCD_BITS-1:0] st_field;
	logic [MT_BITS-1:0] mt_field;
	logic [5:0] st_len;
	logic [5:0] len;
	logic [WORD_BITS-1:0] joined;

	// Coding of one sample; purely combinational, captured by the sequencer
	always_comb
	begin
		res = res_bits_in;
		if (res < ST_MIN_RES)
		begin
			res = ST_MIN_RES;
		end
		else if (res > ST_MAX_RES)
		begin
			res = ST_MAX_RES;
		end
		mask = ST_MAX_BITS'((32'h1 << res) - 32'h1);
		st = (angle_in - zero_offset_in) & mask;
		// Natural codes turn round by mirroring the range
		if (dir_invert_in && code_sel_in != CODE_GRAY)
		begin
			st = mask - st;
		end
		st_field = BCD_BITS'(st);
		mt_field = turns_in;
		st_len = {2'b00, res};
		case (code_sel_in)
			CODE_GRAY:
			begin
				st_field = BCD_BITS'(to_gray(st));
				mt_field = MT_BITS'(to_gray({2'b00, turns_in}));
				if (dir_invert_in)
				begin
					st_field = st_field ^ (BCD_BITS'(1) << (res - 4'h1));
				end
			end
			CODE_BCD:
			begin
				st_field = to_bcd(st);
				st_len = BCD_LEN;
			end
			default:
			begin
				st_field = BCD_BITS'(st);
			end
		endcase
		if (mt_enable_in)
		begin
			len = MT_LEN + st_len;
			joined = ({20'h0_0000, mt_field} << st_len) | {12'h000, st_field};
		end
		else
		begin
			len = st_len;
			joined = {12'h000, st_field};
		end
		word_len_out = len;
		word_out = joined << (WORD_LEN - len);
	end

endmodule
`default_nettype wire

// file: hw/ssi_encoder_port.sv
// Serial absolute encoder port: shift register under a retriggerable one-shot
// Operation
// - Idle: clock and data lines stay high
// - First falling edge starts a readout
// - Each rising edge shifts next bit, MSB first
// - Revolution count goes out before angle
// - After last edge data low for timeout
// - One-shot timer ends transfer and recovery
// - Data only sent in answer to clocks
// - Up to three encoders share a clock
// - Angle width follows resolution, nine to fourteen, except the decimal option at 20
// - Gray option: neighbours differ in one bit
// - Inverted top Gray bit reverses direction
// - Decimal option codes each digit in binary
// - Zero point settable anywhere in range
`timescale 1ns/1ps
`default_nettype none
module ssi_encoder_port
	import ssi_encoder_pkg::*;
(
	input wire logic sys_clk_in,
	input wire logic nrst_in,
	input wire logic ssi_clk_in,
	output logic ssi_data_out,
	output logic busy_out,
	input wire logic [ST_MAX_BITS-1:0] angle_in,
	input wire logic [MT_BITS-1:0] turns_in,
	input wire logic [3:0] res_bits_in,
	input wire logic mt_enable_in,
	input wire code_e code_sel_in,
	input wire logic dir_invert_in,
	input wire logic [ST_MAX_BITS-1:0] zero_offset_in
);

	typedef struct packed {
		logic sync_a;
		logic sync_b;
		logic clk_prev;
		phase_e phase;
		logic [WORD_BITS-1:0] sr;
		logic [COUNT_BITS-1:0] bits_left;
		logic [TIMER_BITS-1:0] timer;
		logic data;
	} port_s;

	// Synchronisers start high so reset release never fakes a start edge
	localparam port_s RESET_STATE = '{
		sync_a: LINK_IDLE_LEVEL,
		sync_b: LINK_IDLE_LEVEL,
		clk_prev: LINK_IDLE_LEVEL,
		phase: PH_IDLE,
		sr: 32'h0000_0000,
		bits_left: 6'h00,
		timer: 9'h000,
		data: LINK_IDLE_LEVEL
	};

	port_s state_reg;
	port_s state_next;
	logic [WORD_BITS-1:0] coded_word;
	logic [COUNT_BITS-1:0] coded_len;
	logic clk_rise;
	logic clk_fall;
	logic link_edge;

	position_coder coder (
		.angle_in(angle_in),
		.turns_in(turns_in),
		.res_bits_in(res_bits_in),
		.mt_enable_in(mt_enable_in),
		.code_sel_in(code_sel_in),
		.dir_invert_in(dir_invert_in),
		.zero_offset_in(zero_offset_in),
		.word_out(coded_word),
		.word_len_out(coded_len)
	);

	// Edges seen only past the second synchroniser stage
	assign clk_rise = state_reg.sync_b & ~state_reg.clk_prev;
	assign clk_fall = ~state_reg.sync_b & state_reg.clk_prev;
	assign link_edge = clk_rise | clk_fall;

	// Next-state logic of the whole port
	always_comb
	begin
		state_next = state_reg;
		state_next.sync_a = ssi_clk_in;
		state_next.sync_b = state_reg.sync_a;
		state_next.clk_prev = state_reg.sync_b;
		if (link_edge)
		begin
			state_next.timer = RECOVERY_CYCLES;
		end
		else if (state_reg.timer != 9'h000)
		begin
			state_next.timer = state_reg.timer - 9'h001;
		end
		case (state_reg.phase)
			PH_IDLE:
			begin
				state_next.data = LINK_IDLE_LEVEL;
				if (clk_fall)
				begin
					state_next.phase = PH_SHIFT;
					state_next.sr = coded_word;
					state_next.bits_left = coded_len;
				end
			end
			PH_SHIFT:
			begin
				if (clk_rise)
				begin
					if (state_reg.bits_left != 6'h00)
					begin
						state_next.data = state_reg.sr[WORD_BITS-1];
						state_next.sr = {state_reg.sr[WORD_BITS-2:0], 1'b0};
						state_next.bits_left = state_reg.bits_left - 6'h01;
					end
					else
					begin
						// extra edge closes word, data low
						state_next.data = DATA_ACK_LEVEL;
						state_next.phase = PH_RECOVER;
					end
				end
				else if (state_reg.sync_b && state_reg.timer == 9'h000 && !link_edge)
				begin
					state_next.phase = PH_IDLE;
					state_next.data = LINK_IDLE_LEVEL;
				end
			end
			PH_RECOVER:
			begin
				state_next.data = DATA_ACK_LEVEL;
				// Timeout only runs while the clock rests high
				if (!state_reg.sync_b)
				begin
					state_next.timer = RECOVERY_CYCLES;
				end
				else if (state_reg.timer == 9'h000 && !link_edge)
				begin
					state_next.phase = PH_IDLE;
					state_next.data = LINK_IDLE_LEVEL;
				end
			end
			default:
			begin
				state_next.phase = PH_IDLE;
				state_next.data = LINK_IDLE_LEVEL;
			end
		endcase
	end

	// Single register bank of the port
	always_ff @(posedge sys_clk_in or negedge nrst_in)
	begin
		if (!nrst_in)
		begin
			state_reg <= RESET_STATE;
		end
		else
		begin
			state_reg <= state_next;
		end
	end

	// Data line comes straight from a flip-flop
	assign ssi_data_out = state_reg.data;
	assign busy_out = (state_reg.phase != PH_IDLE);

	default clocking cb @(posedge sys_clk_in);
	endclocking
	default disable iff (!nrst_in);

	sequence last_rise_s;
		state_reg.phase == PH_SHIFT && clk_rise && state_reg.bits_left == 6'h00;
	endsequence

	sequence low_hold_s;
		(state_reg.phase == PH_RECOVER && !ssi_data_out) [*8];
	endsequence

	sequence start_edge_s;
		state_reg.phase == PH_IDLE && clk_fall;
	endsequence

	idle_data_high_a: assert property (state_reg.phase == PH_IDLE |-> ssi_data_out)
		else $error("data line low while idle");

	start_captures_word_a: assert property (start_edge_s |=> state_reg.phase == PH_SHIFT && state_reg.sr == $past(coded_word) && state_reg.bits_left == $past(coded_len))
		else $error("start edge did not load the coded word");

	shift_msb_first_a: assert property (state_reg.phase == PH_SHIFT && clk_rise && state_reg.bits_left != 6'h00 |=> ssi_data_out == $past(state_reg.sr[WORD_BITS-1]) && state_reg.bits_left == $past(state_reg.bits_left) - 6'h01)
		else $error("rising edge did not shift out the top bit");

	no_unclocked_data_a: assert property (state_reg.phase == PH_IDLE && !clk_fall |=> state_reg.phase == PH_IDLE && ssi_data_out)
		else $error("readout began without a falling clock edge");

	data_stable_between_a: assert property (state_reg.phase == PH_SHIFT && !clk_rise |=> $stable(ssi_data_out))
		else $error("data changed without a rising edge");

	final_edge_low_a: assert property (last_rise_s |=> low_hold_s)
		else $error("data not held low after the final edge");

	recovery_reload_a: assert property (last_rise_s |=> state_reg.timer == RECOVERY_CYCLES)
		else $error("one-shot not loaded on the final edge");

	recovery_end_a: assert property (state_reg.phase == PH_RECOVER && state_reg.sync_b && state_reg.timer == 9'h000 && !link_edge |=> state_reg.phase == PH_IDLE && ssi_data_out)
		else $error("port not ready after the timeout lapsed");

	recovery_low_clock_a: assert property (state_reg.phase == PH_RECOVER && !state_reg.sync_b |=> state_reg.phase == PH_RECOVER && state_reg.timer == RECOVERY_CYCLES)
		else $error("recovery timed out with the clock low");

endmodule
`default_nettype wire

// file: test/ssi_controller_model.sv
// Controller model: drives link clock bursts and captures the data line
`timescale 1ns/1ps
`default_nettype none
module ssi_controller_model
(
	output logic ssi_clk_out,
	input wire logic ssi_data_in
);
	initial ssi_clk_out = 1'b1;

	// start fall, then n+1 rises
	// Bits are taken just before the next rise, since the port answers up to three system clocks (150 ns) late
	// half period per call, longer for long lines
	task automatic read_word(input int n, input int half_ns, output logic [31:0] word,
		output logic tail);
		word = '0;
		#37;
		ssi_clk_out = 1'b0;
		for (int k = 0; k <= n; k++)
		begin
			#(half_ns);
			if (k > 0)
				word = {word[30:0], ssi_data_in};
			ssi_clk_out = 1'b1;
			if (k < n)
			begin
				#(half_ns);
				ssi_clk_out = 1'b0;
			end
		end
		// Tail looked at a fixed time after the last rise, whatever the rate
		#400;
		tail = ssi_data_in;
	endtask

	// Single low pulse; used on purpose inside the recovery time
	task automatic pulse();
		#37;
		ssi_clk_out = 1'b0;
		#200;
		ssi_clk_out = 1'b1;
	endtask
endmodule
`default_nettype wire

// file: test/ssi_absolute_encoder_port_bench.sv
// Self-checking bench for the serial absolute encoder port
`timescale 1ns/1ps
`default_nettype none
module ssi_absolute_encoder_port_bench;
	import ssi_encoder_pkg::*;
	logic sys_clk_in;
	logic nrst_in;
	wire logic ssi_clk;
	wire logic ssi_data;
	wire logic busy;
	logic [ST_MAX_BITS-1:0] angle;
	logic [MT_BITS-1:0] turns;
	logic [3:0] res_bits;
	logic mt_enable;
	code_e code_sel;
	logic dir_invert;
	logic [ST_MAX_BITS-1:0] zero_offset;
	logic [31:0] w1;
	logic [31:0] w2;
	logic tail;
	int miscompares;
	int checks_done;

	ssi_encoder_port i_ssi_encoder_port (.sys_clk_in(sys_clk_in), .nrst_in(nrst_in),
		.ssi_clk_in(ssi_clk), .ssi_data_out(ssi_data), .busy_out(busy), .angle_in(angle),
		.turns_in(turns), .res_bits_in(res_bits), .mt_enable_in(mt_enable),
		.code_sel_in(code_sel), .dir_invert_in(dir_invert), .zero_offset_in(zero_offset));
	ssi_controller_model i_ssi_controller_model (.ssi_clk_out(ssi_clk), .ssi_data_in(ssi_data));

	// 20 MHz system clock
	initial sys_clk_in = 1'b0;
	always #25 sys_clk_in = ~sys_clk_in;

	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		checks_done++;
		if (seen !== exp)
		begin
			miscompares++;
			$display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask

	task automatic report_and_stop();
		$display("Checks %0d, mismatches %0d", checks_done, miscompares);
		if (miscompares == 0 && checks_done > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask

	// Straps change only while the port is idle
	task automatic setup(input logic [3:0] r, input logic mt, input code_e c, input logic inv,
		input logic [13:0] a, input logic [11:0] t, input logic [13:0] z);
		@(negedge sys_clk_in);
		res_bits = r;
		mt_enable = mt;
		code_sel = c;
		dir_invert = inv;
		angle = a;
		turns = t;
		zero_offset = z;
	endtask

	// Data held low for the timeout, then idle again
	task automatic recover_check();
		int c;
		c = 0;
		while (ssi_data === 1'b0 && c < 600)
		begin
			@(negedge sys_clk_in);
			c++;
		end
		check({31'b0, (c > int'(RECOVERY_CYCLES) - 30 && c <= int'(RECOVERY_CYCLES) + 20)}, 32'h1);
		@(negedge sys_clk_in);
		check({31'b0, busy}, 32'h0);
	endtask

	task automatic readout(input int n, input logic [31:0] exp, output logic [31:0] w);
		@(negedge sys_clk_in);
		i_ssi_controller_model.read_word(n, 200, w, tail);
		check(w, exp);
		check({31'b0, tail}, 32'h0);
		recover_check();
	endtask

	task automatic idle_test();
		repeat (50) @(negedge sys_clk_in);
		check({30'b0, ssi_data, busy}, 32'h2);
	endtask

	task automatic width_test();
		setup(4'h9, 1'b0, CODE_BINARY, 1'b0, 14'h0135, 12'h000, 14'h0000);
		readout(9, 32'h135, w1);
		setup(4'hE, 1'b1, CODE_BINARY, 1'b0, 14'h2C5A, 12'hA53, 14'h0000);
		readout(26, {6'h00, 12'hA53, 14'h2C5A}, w1);
		setup(4'h9, 1'b1, CODE_GRAY, 1'b0, 14'h0003, 12'h005, 14'h0000);
		readout(21, 32'h0E02, w1);
		// Out-of-range resolution clamps to 14, spare code acts as binary
		setup(4'hF, 1'b0, code_e'(2'h3), 1'b0, 14'h2C5A, 12'h000, 14'h0000);
		readout(14, 32'h2C5A, w1);
	endtask

	// Nominal rate, then the slowest long-line rate
	task automatic rate_test();
		setup(4'h9, 1'b0, CODE_BINARY, 1'b0, 14'h00C3, 12'h000, 14'h0000);
		@(negedge sys_clk_in);
		i_ssi_controller_model.read_word(9, 500, w1, tail);
		check(w1, 32'h0C3);
		recover_check();
		@(negedge sys_clk_in);
		i_ssi_controller_model.read_word(9, 5000, w1, tail);
		check(w1, 32'h0C3);
		check({31'b0, tail}, 32'h0);
		recover_check();
	endtask

	// Neighbouring angles across the half-turn boundary
	task automatic gray_test();
		setup(4'hC, 1'b0, CODE_GRAY, 1'b0, 14'h07FF, 12'h000, 14'h0000);
		readout(12, 32'h400, w1);
		setup(4'hC, 1'b0, CODE_GRAY, 1'b0, 14'h0800, 12'h000, 14'h0000);
		readout(12, 32'hC00, w2);
		check({31'b0, $countones(w1 ^ w2) == 1}, 32'h1);
	endtask

	task automatic invert_test();
		setup(4'hA, 1'b0, CODE_GRAY, 1'b1, 14'h0005, 12'h000, 14'h0000);
		readout(10, 32'h207, w1);
		setup(4'hA, 1'b0, CODE_BINARY, 1'b1, 14'h0005, 12'h000, 14'h0000);
		readout(10, 32'h3FA, w1);
	endtask

	task automatic code_test();
		setup(4'hE, 1'b0, CODE_BCD, 1'b0, 14'h3039, 12'h000, 14'h0000);
		readout(20, 32'h12345, w1);
		setup(4'h9, 1'b0, CODE_BINARY, 1'b0, 14'h0005, 12'h000, 14'h000A);
		readout(9, 32'h1FB, w1);
	endtask

	// Angle moves mid-word; the word must still show the start value
	task automatic capture_test();
		setup(4'hB, 1'b0, CODE_BINARY, 1'b0, 14'h04A5, 12'h000, 14'h0000);
		fork
			readout(11, 32'h4A5, w1);
			begin
				repeat (30) @(negedge sys_clk_in);
				angle = 14'h0000;
			end
		join
	endtask

	// Clock dropped too early: port stays low and restarts its timeout
	task automatic early_fall_test();
		setup(4'h9, 1'b0, CODE_BINARY, 1'b0, 14'h0000, 12'h000, 14'h0000);
		@(negedge sys_clk_in);
		i_ssi_controller_model.read_word(9, 200, w1, tail);
		repeat (100) @(negedge sys_clk_in);
		i_ssi_controller_model.pulse();
		repeat (10) @(negedge sys_clk_in);
		check({31'b0, ssi_data}, 32'h0);
		recover_check();
	endtask

	initial
	begin
		miscompares = 0;
		checks_done = 0;
		nrst_in = 1'b0;
		res_bits = 4'h9;
		mt_enable = 1'b0;
		code_sel = CODE_BINARY;
		dir_invert = 1'b0;
		angle = '0;
		turns = '0;
		zero_offset = '0;
		repeat (4) @(negedge sys_clk_in);
		nrst_in = 1'b1;
		idle_test();
		width_test();
		gray_test();
		invert_test();
		code_test();
		capture_test();
		rate_test();
		early_fall_test();
		report_and_stop();
	end

	// Watchdog: several times the expected run
	initial
	begin
		#2_000_000;
		miscompares++;
		report_and_stop();
	end
endmodule
`default_nettype wire
